// ---- src/spw_pkg.sv ----
// package for the status protect write and identification read block
// assumes a single mclk domain; link pins are synchronised inside the block
package spw_pkg;
   localparam logic [7:0] SPW_OP_ARM       = 8'h50; // status_write_arm opcode
   localparam logic [7:0] SPW_OP_WRITE     = 8'h01; // status_write_cmd opcode
   localparam logic [7:0] SPW_OP_ID_A      = 8'h90; // identification_read opcode
   localparam logic [7:0] SPW_OP_ID_B      = 8'hAB; // identification_read alternate
   localparam int         SPW_ADDR_BITS    = 24;    // address length after id opcode
   localparam int         SPW_POS_BP_LO    = 2;     // block_protect_lo position
   localparam int         SPW_POS_BP_HI    = 3;     // block_protect_hi position
   localparam int         SPW_POS_LOCK     = 7;     // protect_lockdown position
   localparam logic [7:0] SPW_WR_MASK      = 8'h8C; // writable status bits
   localparam logic [7:0] SPW_STATUS_RST   = 8'h1C; // status value after reset
   localparam logic [7:0] SPW_MFR_CODE     = 8'h5A; // arbitrary manufacturer code
   localparam logic [7:0] SPW_DEV_CODE     = 8'h3C; // arbitrary device code
   typedef enum logic [2:0] {SPW_OPC, SPW_WDATA, SPW_IDADR, SPW_IDOUT, SPW_SKIP} spw_state_t;
endpackage

// ---- src/spw_core.sv ----
// status protect write sequencing and identification read on the serial link
// assumes spi mode 0 or 3 host; sck/cs/si/wp are asynchronous pins
`timescale 1ns/1ps
module spw_core
   import spw_pkg::*;
#(
   parameter logic [7:0] MFR_CODE = SPW_MFR_CODE, // arbitrary value
   parameter logic [7:0] DEV_CODE = SPW_DEV_CODE  // arbitrary value
)(
   input  wire logic       mclk,      // 250 MHz system clock
   input  wire logic       reset,     // async reset, active high
   input  wire logic       cs_n,      // chip select pin, active low
   input  wire logic       sck,       // serial clock pin
   input  wire logic       si,        // serial data in pin
   input  wire logic       wp_n,      // write-protect pin, active low
   output logic            so,        // serial data out
   output logic            so_oe,     // high while driving so
   output logic [7:0]      status,    // status register contents
   output logic [7:0]      opcode,    // last opcode byte for the decoder
   output logic            op_valid,  // one-cycle pulse on each opcode byte
   output logic            cs_rise    // one-cycle pulse on chip-select rise
);
   // two-flop synchronisers and edge history
   logic [1:0] cs_s_q, sck_s_q, si_s_q, wp_s_q;
   logic       cs_h_q, sck_h_q;
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         cs_s_q  <= 2'h3;
         sck_s_q <= 2'h0;
         si_s_q  <= 2'h0;
         wp_s_q  <= 2'h0;
         cs_h_q  <= 1'b1;
         sck_h_q <= 1'b0;
      end
      else
      begin
         cs_s_q  <= {cs_s_q[0], cs_n};
         sck_s_q <= {sck_s_q[0], sck};
         si_s_q  <= {si_s_q[0], si};
         wp_s_q  <= {wp_s_q[0], wp_n};
         cs_h_q  <= cs_s_q[1];
         sck_h_q <= sck_s_q[1];
      end
   end

   logic cs_lo, sck_up, sck_dn, cs_up, wp_hi;
   assign cs_lo  = ~cs_s_q[1];
   assign sck_up = cs_lo & sck_s_q[1] & ~sck_h_q;
   assign sck_dn = cs_lo & ~sck_s_q[1] & sck_h_q;
   assign cs_up  = cs_s_q[1] & ~cs_h_q;
   assign wp_hi  = wp_s_q[1];

   // status merge on an allowed write
   function automatic logic [7:0] spw_merge(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic       wp_high);
      logic [7:0] r;
      r = (old_v & ~SPW_WR_MASK) | (new_v & SPW_WR_MASK);
      if (!wp_high)
         r[SPW_POS_LOCK] = old_v[SPW_POS_LOCK] | new_v[SPW_POS_LOCK];
      return r;
   endfunction

   spw_state_t st_q, st_d;
   logic [7:0]  sh_q, sh_d;
   logic [4:0]  cnt_q, cnt_d;
   logic        arm_q, arm_d;        // arm seen in previous instruction
   logic        armed_q, armed_d;    // current instruction is a write that follows an arm
   logic        wr_ok_q, wr_ok_d;    // full data byte captured
   logic [7:0]  wdat_q, wdat_d;
   logic [7:0]  stat_q, stat_d;
   logic [7:0]  out_q, out_d;
   logic [7:0]  op_q, op_d;
   logic        opv_q, opv_d;
   logic        sel_q, sel_d;        // which id byte comes next
   logic        so_q, so_d;
   logic        oe_q, oe_d;
   logic [7:0]  nb;

   // next-state logic
   always_comb
   begin
      nb      = {sh_q[6:0], si_s_q[1]};
      st_d    = st_q;
      sh_d    = sh_q;
      cnt_d   = cnt_q;
      arm_d   = arm_q;
      armed_d = armed_q;
      wr_ok_d = wr_ok_q;
      wdat_d  = wdat_q;
      stat_d  = stat_q;
      out_d   = out_q;
      op_d    = op_q;
      opv_d   = 1'b0;
      sel_d   = sel_q;
      so_d    = so_q;
      oe_d    = oe_q;
      if (cs_up)
      begin
         // end of instruction: commit an allowed write on chip-select rise
         // wr_ok_q marks a complete data byte; the state has already left the data phase
         if (armed_q && wr_ok_q &&
             (wp_hi || !stat_q[SPW_POS_LOCK]))
            stat_d = spw_merge(stat_q, wdat_q, wp_hi);
         arm_d   = (st_q == SPW_SKIP) && (op_q == SPW_OP_ARM);
         armed_d = 1'b0;
         wr_ok_d = 1'b0;
         st_d    = SPW_OPC;
         cnt_d   = '0;
         oe_d    = 1'b0;
      end
      else if (!cs_lo)
      begin
         st_d  = SPW_OPC;
         cnt_d = '0;
         oe_d  = 1'b0;
      end
      else if (sck_up)
      begin
         sh_d  = nb;
         cnt_d = cnt_q + 5'h01;
         case (st_q)
            SPW_OPC:
            begin
               if (cnt_q == 5'h07)
               begin
                  cnt_d   = '0;
                  op_d    = nb;
                  opv_d   = 1'b1;
                  armed_d = arm_q && (nb == SPW_OP_WRITE);
                  arm_d   = 1'b0;
                  if (nb == SPW_OP_WRITE)
                     st_d = SPW_WDATA;
                  else if (nb == SPW_OP_ID_A || nb == SPW_OP_ID_B)
                     st_d = SPW_IDADR;
                  else
                     st_d = SPW_SKIP;
               end
            end
            SPW_WDATA:
            begin
               if (cnt_q == 5'h07)
               begin
                  wdat_d  = nb;
                  wr_ok_d = 1'b1;
                  st_d    = SPW_SKIP;
               end
            end
            SPW_IDADR:
            begin
               if (cnt_q == 5'(SPW_ADDR_BITS - 1))
               begin
                  sel_d = nb[0];
                  out_d = nb[0] ? DEV_CODE : MFR_CODE;
                  cnt_d = '0;
                  st_d  = SPW_IDOUT;
               end
            end
            SPW_IDOUT:
            begin
               if (cnt_q == 5'h07)
                  cnt_d = '0;
            end
            default: cnt_d = '0;
         endcase
      end
      else if (sck_dn && st_q == SPW_IDOUT)
      begin
         // shift id bits on falling sck, alternate byte each eight bits
         so_d  = out_q[7];
         oe_d  = 1'b1;
         out_d = {out_q[6:0], 1'b0};
         if (cnt_q == 5'h00)
         begin
            so_d  = sel_q ? DEV_CODE[7] : MFR_CODE[7];
            out_d = {(sel_q ? DEV_CODE[6:0] : MFR_CODE[6:0]), 1'b0};
            sel_d = ~sel_q;
         end
      end
   end

   // state registers
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         st_q    <= SPW_OPC;
         sh_q    <= 8'h00;
         cnt_q   <= 5'h00;
         arm_q   <= 1'b0;
         armed_q <= 1'b0;
         wr_ok_q <= 1'b0;
         wdat_q  <= 8'h00;
         stat_q  <= SPW_STATUS_RST;
         out_q   <= 8'h00;
         op_q    <= 8'h00;
         opv_q   <= 1'b0;
         sel_q   <= 1'b0;
         so_q    <= 1'b0;
         oe_q    <= 1'b0;
      end
      else
      begin
         st_q    <= st_d;
         sh_q    <= sh_d;
         cnt_q   <= cnt_d;
         arm_q   <= arm_d;
         armed_q <= armed_d;
         wr_ok_q <= wr_ok_d;
         wdat_q  <= wdat_d;
         stat_q  <= stat_d;
         out_q   <= out_d;
         op_q    <= op_d;
         opv_q   <= opv_d;
         sel_q   <= sel_d;
         so_q    <= so_d;
         oe_q    <= oe_d;
      end
   end

   // outputs
   assign so       = so_q;
   assign so_oe    = oe_q;
   assign status   = stat_q;
   assign opcode   = op_q;
   assign op_valid = opv_q;
   assign cs_rise  = cs_up;

   // status write checks
   a_unwritable_bits: assert property (@(posedge mclk) disable iff (reset)
      (stat_q & ~SPW_WR_MASK) == ($past(stat_q) & ~SPW_WR_MASK))
      else $error("unwritable status bit changed");
   a_update_on_rise: assert property (@(posedge mclk) disable iff (reset)
      (stat_q != $past(stat_q)) |-> $past(cs_up))
      else $error("status changed without chip-select rise");
   a_lock_holds: assert property (@(posedge mclk) disable iff (reset)
      ($past(stat_q[SPW_POS_LOCK]) && !$past(wp_hi)) |-> stat_q == $past(stat_q))
      else $error("locked status changed");
   a_lock_no_clear: assert property (@(posedge mclk) disable iff (reset)
      $fell(stat_q[SPW_POS_LOCK]) |-> $past(wp_hi))
      else $error("lockdown cleared while protected");
   a_write_needs_arm: assert property (@(posedge mclk) disable iff (reset)
      (stat_q != $past(stat_q)) |-> $past(armed_q))
      else $error("status written without arm");
   a_arm_dropped: assert property (@(posedge mclk) disable iff (reset)
      (opv_q && op_q != SPW_OP_WRITE) |-> !armed_q && !arm_q)
      else $error("arming survived another instruction");
   a_unlocked_write: assert property (@(posedge mclk) disable iff (reset)
      (cs_up && armed_q && wr_ok_q && wp_hi)
      |=> stat_q == (($past(stat_q) & ~SPW_WR_MASK) | ($past(wdat_q) & SPW_WR_MASK)))
      else $error("free status write not applied");
   // refusal decided from pin and lockdown as they stand at the rise
   a_locked_refused: assert property (@(posedge mclk) disable iff (reset)
      (cs_up && !wp_hi && stat_q[SPW_POS_LOCK]) |=> stat_q == $past(stat_q))
      else $error("locked status write applied");
   // protected but unlocked: lockdown and block-protect change together
   a_lock_set_low: assert property (@(posedge mclk) disable iff (reset)
      (cs_up && armed_q && wr_ok_q && !wp_hi && !stat_q[SPW_POS_LOCK])
      |=> stat_q == (($past(stat_q) & ~SPW_WR_MASK) | ($past(wdat_q) & SPW_WR_MASK)))
      else $error("protected status write not applied");
   // an instruction that was not armed leaves status alone
   a_no_write_unarmed: assert property (@(posedge mclk) disable iff (reset)
      (cs_up && !armed_q) |=> stat_q == $past(stat_q))
      else $error("unarmed status write applied");
   // rise detector gives a single-cycle pulse
   a_rise_pulse: assert property (@(posedge mclk) disable iff (reset)
      cs_up |=> !cs_up)
      else $error("chip-select rise pulse too long");

   // identification output checks
   a_id_enter: assert property (@(posedge mclk) disable iff (reset)
      (opv_q && (op_q == SPW_OP_ID_A || op_q == SPW_OP_ID_B)) |-> st_q == SPW_IDADR)
      else $error("id opcode not decoded");
   a_oe_off: assert property (@(posedge mclk) disable iff (reset)
      cs_up |=> !oe_q)
      else $error("output still driven after deselect");
   // output enable only in the identification output phase
   a_oe_in_id: assert property (@(posedge mclk) disable iff (reset)
      oe_q |-> st_q == SPW_IDOUT)
      else $error("output driven outside id phase");
   // each id byte starts with bit 7 of the selected code
   a_first_id_bit: assert property (@(posedge mclk) disable iff (reset)
      (sck_dn && st_q == SPW_IDOUT && cnt_q == 5'h00)
      |=> so_q == ($past(sel_q) ? DEV_CODE[7] : MFR_CODE[7]))
      else $error("id byte started with wrong bit");
   // serial output moves only on a falling serial clock
   a_so_on_fall: assert property (@(posedge mclk) disable iff (reset)
      $changed(so_q) |-> $past(sck_dn))
      else $error("serial output changed off a falling edge");
endmodule

// ---- dv/spw_host.sv ----
// serial host model: drives chip select, serial clock, data in and write-protect
// assumes mclk at 4 ns; sck runs at 32 ns only inside a frame, mode 0
`timescale 1ns/1ps
module spw_host (
   input  wire logic mclk,   // bench clock
   output logic      cs_n,   // chip select, active low
   output logic      sck,    // serial clock
   output logic      si,     // serial data to device
   output logic      wp_n,   // write-protect pin
   input  wire logic so      // serial data from device
);
   initial
   begin
      cs_n = 1'b1;
      sck  = 1'b0;
      si   = 1'b0;
      wp_n = 1'b1;
   end
   task automatic wt(input int k);
      repeat (k) @(posedge mclk);
   endtask
   // one frame: n bits msb first, wp set late, so sampled at end of high phase
   task automatic xfer(input int n, input logic [47:0] b, input logic wp_end,
                       output logic [15:0] rd);
      rd = '0;
      cs_n <= 1'b0;
      wt(4);
      for (int i = 0; i < n; i++)
      begin
         si <= b[47-i];
         wt(4);
         sck <= 1'b1;
         wt(4);
         rd = {rd[14:0], so};
         sck <= 1'b0;
      end
      wt(4);
      wp_n <= wp_end;
      wt(4);
      cs_n <= 1'b1;
      si <= ~si;
      wt(26);
   endtask
endmodule

// ---- dv/spw_core_bench.sv ----
// self-checking bench for the status write sequence and identification read
// assumes spw_host as far side; status checked after every chip-select rise
`timescale 1ns/1ps
module spw_core_bench;
   import spw_pkg::*;
   logic        mclk = 1'b0;
   logic        reset = 1'b1;
   wire logic   cs_n, sck, si, wp_n, so, so_oe, op_valid, cs_rise;
   wire logic [7:0] status, opcode;
   int          err_count = 0;
   int          samples_checked = 0;
   logic [7:0]  st = SPW_STATUS_RST;
   logic [8:0]  exp_q[$];        // {id frame, status} per frame
   logic [7:0]  opc_q[$];        // opcode per frame
   logic [8:0]  ex;
   logic        oe_seen = 1'b0;  // output enable seen in this frame
   logic        armed = 1'b0;
   logic [31:0] rng = 32'h8BCB;
   logic [15:0] rd;
   // clock
   always #2 mclk = ~mclk;
   spw_core dut (.mclk(mclk), .reset(reset), .cs_n(cs_n), .sck(sck), .si(si),
      .wp_n(wp_n), .so(so), .so_oe(so_oe), .status(status), .opcode(opcode),
      .op_valid(op_valid), .cs_rise(cs_rise));
   spw_host host (.mclk(mclk), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .so(so));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("checked %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // frame with expected status noted before it is sent
   task automatic cmd(input logic [7:0] opc, input logic [7:0] d, input logic wp, input int n);
      if (opc == SPW_OP_WRITE && armed && n >= 16 && (wp || !st[SPW_POS_LOCK]))
         st = (st & ~SPW_WR_MASK) | (d & SPW_WR_MASK);
      armed = (opc == SPW_OP_ARM && n == 8);
      exp_q.push_back({1'b0, st});
      if (n >= 8)
         opc_q.push_back(opc);
      host.xfer(n, {opc, d, 32'h0}, wp, rd);
   endtask
   // identification read of two bytes
   task automatic idrd(input logic [7:0] opc, input logic a);
      armed = 1'b0;
      exp_q.push_back({1'b1, st});
      opc_q.push_back(opc);
      host.xfer(48, {opc, 23'h0, a, 16'h0}, wp_n, rd);
      chk8(rd[15:8], a ? SPW_DEV_CODE : SPW_MFR_CODE);
      chk8(rd[7:0], a ? SPW_MFR_CODE : SPW_DEV_CODE);
   endtask
   // watcher: outputs looked at 1 ns after each rising mclk edge, once settled
   always @(posedge mclk)
   begin
      #1;
      if (so_oe === 1'b1)
         oe_seen = 1'b1;
      if (op_valid === 1'b1)
      begin
         if (opc_q.size() == 0)
            chk8(opcode, 8'hXX);
         else
            chk8(opcode, opc_q.pop_front());
      end
      if (cs_rise === 1'b1)
      begin
         if (exp_q.size() == 0)
            ex = 'x;
         else
            ex = exp_q.pop_front();
         chk8({7'h00, oe_seen}, {7'h00, ex[8]});
         oe_seen = 1'b0;
         @(posedge mclk);
         #1;
         chk8(status, ex[7:0]);
         chk8({7'h00, so_oe}, 8'h00);
      end
   end
   // hang guard
   initial
   begin
      #200000;
      err_count++;
      close_out();
   end
   // main sequence
   initial
   begin
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      host.wt(4);
      idrd(SPW_OP_ID_A, 1'b0);
      idrd(SPW_OP_ID_B, 1'b1);
      $display("id read test done");
      cmd(SPW_OP_ARM, 8'h00, 1'b1, 8);
      cmd(SPW_OP_WRITE, 8'h77, 1'b1, 16);
      cmd(SPW_OP_WRITE, 8'h00, 1'b1, 16);
      cmd(SPW_OP_ARM, 8'h00, 1'b1, 8);
      cmd(SPW_OP_WRITE, 8'h00, 1'b1, 12);
      cmd(SPW_OP_ARM, 8'h00, 1'b1, 8);
      idrd(SPW_OP_ID_A, 1'b0);
      cmd(SPW_OP_WRITE, 8'h00, 1'b1, 16);
      $display("arm sequence test done");
      cmd(SPW_OP_ARM, 8'h00, 1'b0, 8);
      cmd(SPW_OP_WRITE, 8'h84, 1'b0, 16);
      cmd(SPW_OP_ARM, 8'h00, 1'b0, 8);
      cmd(SPW_OP_WRITE, 8'h00, 1'b0, 16);
      cmd(SPW_OP_ARM, 8'h00, 1'b0, 8);
      cmd(SPW_OP_WRITE, 8'h08, 1'b1, 16);
      $display("protect pin test done");
      for (int i = 0; i < 8; i++)
      begin
         rng = xs(rng);
         cmd(SPW_OP_ARM, 8'h00, rng[9], 8);
         cmd(SPW_OP_WRITE, rng[7:0], rng[8], 16);
      end
      $display("random write test done");
      host.wt(20);
      chk8(8'(exp_q.size() + opc_q.size()), 8'h00);
      close_out();
   end
endmodule
